/* File: rtl/dws_pkg.sv */
// Package for the converter waveform sequencer: register map, field layout, modes and structs.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses on a word grid.
package dws_pkg;

  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned TIMEBASE_HZ = 80_000_000;
  localparam int unsigned NCH = 4;
  localparam int unsigned SAMPLE_W = 16;
  localparam int unsigned FIFO_DEPTH = 512;
  localparam int unsigned ADDR_W = 8;

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_INTERVAL = 8'h0c;
  localparam logic [7:0] REG_RUNLEN = 8'h10;
  localparam logic [7:0] REG_REPEAT = 8'h14;
  localparam logic [7:0] REG_DELAY = 8'h18;
  localparam logic [7:0] REG_GAP = 8'h1c;
  localparam logic [7:0] REG_TRIGLIM = 8'h20;
  localparam logic [7:0] REG_CMD = 8'h24;
  localparam logic [7:0] REG_SWITCH = 8'h28;

  // Control register fields.
  localparam int unsigned CTL_CH_EN = 0;
  localparam int unsigned CTL_WAVE = 4;
  localparam int unsigned CTL_DELAY_EN = 5;
  localparam int unsigned CTL_RETRIG = 6;
  localparam int unsigned CTL_REPEAT_EN = 7;
  localparam int unsigned CTL_TRIG_PIN = 8;
  localparam int unsigned CTL_DLY_SRC = 9;
  localparam int unsigned CTL_EXPORT = 10;
  localparam int unsigned CTL_GAP_EN = 12;
  localparam int unsigned CTL_RELOAD = 13;

  // Command register bits, all self-clearing.
  localparam int unsigned CMD_SW_TRIG = 0;
  localparam int unsigned CMD_TRIG_RESET = 1;
  localparam int unsigned CMD_FIFO_CLR = 2;
  localparam int unsigned CMD_STOP = 3;

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] INTERVAL_RST = 32'h0000_0050;
  localparam logic [31:0] ONE32 = 32'h0000_0001;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  localparam logic [1:0] ONE_CH = 2'h1;
  localparam logic [31:0] BUS_ZERO = 32'h0000_0000;

  typedef enum logic [4:0] {
    DWS_IDLE  = 5'h01,
    DWS_DELAY = 5'h02,
    DWS_RUN   = 5'h04,
    DWS_GAP   = 5'h08,
    DWS_DONE  = 5'h10
  } dws_state_t;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] interval;
    logic [31:0] runlen;
    logic [31:0] repeats;
    logic [31:0] delay;
    logic [31:0] gap;
    logic [31:0] triglim;
    logic [NCH-1:0] sw_on;
  } dws_cfg_t;

  typedef struct packed {
    logic [SAMPLE_W-1:0] code;
    logic [1:0] chan;
    logic wr;
    logic load;
  } dws_conv_t;

endpackage : dws_pkg

/* File: rtl/dws_sequencer.sv */
// Waveform sequencer for four converter channels: Wishbone slave, sample FIFO and pacing counters.
// Assumes one 200 MHz clock, synchronous reset, and converter chips that move held codes on load.
// The DMA engine writes the data register over the same bus as software does.
//
// Our own choices: the placing of the registers and register access over Wishbone.

////////////////////////////////////////////////////////////////////////////////
// Function
// - Four channels; all enabled ones receive one shared load so outputs change together.
// - Codes go to converter holding registers first; a separate load moves them to output.
// - Interval counter counts down from the programmed value; at zero the next sample is written.
// - Waveform mode buffers samples in a 512-entry first-in first-out queue.
// - Longer waveforms are refilled by DMA writes to the queue while generation runs.
// - Stream is interleaved in channel order; disabled channels take no samples.
// - Each channel output switch is off after reset; only a software write closes it.
// - Codes are straight binary, 0x0000 is -10 V, 0x8000 is 0 V, 0xc000 is +5 V.
// - Software update mode gives exactly one load per software data write.
// - A 32-bit interval sets update spacing in 80 MHz timebase ticks.
// - A 32-bit run length sets samples per run; shorter runs walk the pattern in pieces.
// - A 32-bit repeat count sets how many runs follow a trigger, in every trigger mode.
// - Post-trigger mode outputs run length times repeat count samples right after a trigger.
// - Delay-trigger mode counts a 32-bit start delay down on its clock before generation.
// - Software selects the start delay clock source, the 80 MHz timebase among them.
// - With retrigger, a 32-bit limit caps accepted triggers until a trigger reset command.
// - Triggers arriving while generating are ignored and not counted.
// - Repeat enabled with value zero repeats forever until repeat is disabled; the code stops after 2^32 runs.
// - A waveform that fits the queue is replayed without fetching again.
// - In iterative mode a 32-bit gap counter runs after each run; at zero the next starts.
// - Either of function pins zero and one can serve as the external start trigger.
// - Function pins zero and one can export the converter load strobe.
module dws_sequencer #(
  parameter int unsigned DEPTH = dws_pkg::FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [dws_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Function pins.
  input wire logic function_pin_zero_i,
  input wire logic function_pin_one_i,
  output logic function_pin_zero_o,
  output logic function_pin_one_o,
  output logic function_pin_zero_oe_o,
  output logic function_pin_one_oe_o,
  // Converter side.
  output dws_pkg::dws_conv_t conv_o,
  output logic [dws_pkg::NCH-1:0] out_switch_o
);

  localparam int unsigned AW = $clog2(DEPTH);
  // Timebase ticks come from a fractional accumulator: 80 of every 200 clocks.
  localparam logic [7:0] TB_ADD = 8'(dws_pkg::TIMEBASE_HZ / 1_000_000);
  localparam logic [7:0] TB_MOD = 8'(dws_pkg::CLK_HZ / 1_000_000);

  typedef struct packed {
    dws_pkg::dws_cfg_t cfg;
    dws_pkg::dws_state_t st;
    logic ack;
    logic [31:0] rdat;
    logic [7:0] tb_acc;
    logic [2:0] p0;
    logic [2:0] p1;
    logic trig_prev;
    logic [AW:0] wptr;
    logic [AW:0] rptr;
    logic [AW:0] base;
    logic [31:0] ui;
    logic [31:0] uc;
    logic [31:0] ic;
    logic [31:0] dly;
    logic [31:0] accepted;
    logic [1:0] ch;
    logic loaded;
    dws_pkg::dws_conv_t conv;
    logic pin0;
    logic pin1;
    logic oe0;
    logic oe1;
  } dws_state_all_t;

  dws_state_all_t s_r;
  dws_state_all_t s_nxt;
  logic [dws_pkg::SAMPLE_W-1:0] mem_r [DEPTH];

  logic tb_tick;
  logic wr_acc;
  logic rd_acc;
  logic [7:0] off;
  logic fifo_push;
  logic [AW:0] level;
  logic trig_lvl;
  logic trig;
  logic dly_tick;
  logic [1:0] next_ch;
  logic [1:0] first_ch;
  logic [dws_pkg::NCH-1:0] en;

  always_comb
  begin
    s_nxt = s_r;
    en = s_r.cfg.ctrl[dws_pkg::CTL_CH_EN +: dws_pkg::NCH];
    off = wb_adr_i;
    wr_acc = wb_cyc_i && wb_stb_i && !s_r.ack && wb_we_i;
    rd_acc = wb_cyc_i && wb_stb_i && !s_r.ack && !wb_we_i;
    level = s_r.wptr - s_r.rptr;
    fifo_push = wr_acc && off == dws_pkg::REG_DATA && level != (AW+1)'(DEPTH);
    tb_tick = s_r.tb_acc + TB_ADD >= TB_MOD;
    s_nxt.tb_acc = tb_tick ? s_r.tb_acc + TB_ADD - TB_MOD : s_r.tb_acc + TB_ADD;
    // Three-stage pin sampling; a level change counts once stages two and three agree.
    s_nxt.p0 = {s_r.p0[1:0], function_pin_zero_i};
    s_nxt.p1 = {s_r.p1[1:0], function_pin_one_i};
    trig_lvl = s_r.cfg.ctrl[dws_pkg::CTL_TRIG_PIN] ? s_r.p1[2] : s_r.p0[2];
    if ((s_r.cfg.ctrl[dws_pkg::CTL_TRIG_PIN] ? s_r.p1[1] : s_r.p0[1]) == trig_lvl)
    begin
      s_nxt.trig_prev = trig_lvl;
    end
    trig = (trig_lvl && !s_r.trig_prev && s_r.p0[1] == s_r.p0[2] && s_r.p1[1] == s_r.p1[2])
      || (wr_acc && off == dws_pkg::REG_CMD && wb_dat_i[dws_pkg::CMD_SW_TRIG]);
    dly_tick = s_r.cfg.ctrl[dws_pkg::CTL_DLY_SRC] ? 1'b1 : tb_tick;
    // A frame always opens on the lowest enabled channel, also right after a trigger.
    first_ch = 2'h0;
    for (int k = dws_pkg::NCH - 1; k >= 0; k--)
    begin
      if (en[k])
      begin
        first_ch = 2'(k);
      end
    end
    next_ch = first_ch;
    for (int k = dws_pkg::NCH - 1; k >= 0; k--)
    begin
      if (k > int'(s_r.ch) && en[k])
      begin
        next_ch = 2'(k);
      end
    end
    s_nxt.conv.wr = 1'b0;
    s_nxt.conv.load = 1'b0;
    s_nxt.ack = wb_cyc_i && wb_stb_i && !s_r.ack;
    // Register writes.
    if (wr_acc)
    begin
      unique case (off)
        dws_pkg::REG_CTRL: s_nxt.cfg.ctrl = wb_dat_i;
        dws_pkg::REG_INTERVAL: s_nxt.cfg.interval = wb_dat_i;
        dws_pkg::REG_RUNLEN: s_nxt.cfg.runlen = wb_dat_i;
        dws_pkg::REG_REPEAT: s_nxt.cfg.repeats = wb_dat_i;
        dws_pkg::REG_DELAY: s_nxt.cfg.delay = wb_dat_i;
        dws_pkg::REG_GAP: s_nxt.cfg.gap = wb_dat_i;
        dws_pkg::REG_TRIGLIM: s_nxt.cfg.triglim = wb_dat_i;
        dws_pkg::REG_SWITCH: s_nxt.cfg.sw_on = wb_dat_i[dws_pkg::NCH-1:0];
        default: ;
      endcase
    end
    if (wr_acc && off == dws_pkg::REG_CMD && wb_dat_i[dws_pkg::CMD_TRIG_RESET])
    begin
      s_nxt.accepted = dws_pkg::ZERO32;
    end
    if (fifo_push)
    begin
      s_nxt.wptr = s_r.wptr + (AW+1)'(1);
    end
    // Software update: the written code goes straight to the selected holding register, then loads.
    if (wr_acc && off == dws_pkg::REG_DATA && !s_r.cfg.ctrl[dws_pkg::CTL_WAVE])
    begin
      s_nxt.wptr = s_r.wptr;
      s_nxt.conv.code = wb_dat_i[dws_pkg::SAMPLE_W-1:0];
      s_nxt.conv.chan = wb_dat_i[dws_pkg::SAMPLE_W +: 2];
      s_nxt.conv.wr = 1'b1;
      s_nxt.loaded = 1'b1;
    end
    if (s_r.loaded)
    begin
      s_nxt.loaded = 1'b0;
      s_nxt.conv.load = 1'b1;
    end
    // Waveform sequencing.
    unique case (s_r.st)
      dws_pkg::DWS_IDLE:
      begin
        if (trig && s_r.cfg.ctrl[dws_pkg::CTL_WAVE] && !(s_r.cfg.ctrl[dws_pkg::CTL_RETRIG]
            && s_r.accepted >= s_r.cfg.triglim))
        begin
          s_nxt.accepted = s_r.accepted + dws_pkg::ONE32;
          s_nxt.dly = s_r.cfg.delay;
          s_nxt.ic = s_r.cfg.repeats;
          s_nxt.uc = s_r.cfg.runlen;
          s_nxt.ui = s_r.cfg.interval;
          s_nxt.ch = first_ch;
          s_nxt.st = s_r.cfg.ctrl[dws_pkg::CTL_DELAY_EN] ? dws_pkg::DWS_DELAY
                                                          : dws_pkg::DWS_RUN;
        end
      end
      dws_pkg::DWS_DELAY:
      begin
        if (s_r.dly == dws_pkg::ZERO32)
        begin
          s_nxt.st = dws_pkg::DWS_RUN;
        end
        else if (dly_tick)
        begin
          s_nxt.dly = s_r.dly - dws_pkg::ONE32;
        end
      end
      dws_pkg::DWS_RUN:
      begin
        // Triggers are not examined here, so they are neither honoured nor counted.
        // The tick of the write cycle counts toward the next interval, so spacing is exact.
        if (tb_tick && s_r.ui != dws_pkg::ZERO32)
        begin
          s_nxt.ui = s_r.ui - dws_pkg::ONE32;
        end
        if (s_r.ui == dws_pkg::ZERO32 && level != '0 && !s_r.loaded)
        begin
          s_nxt.ui = tb_tick ? s_r.cfg.interval - dws_pkg::ONE32 : s_r.cfg.interval;
          s_nxt.conv.code = mem_r[s_r.rptr[AW-1:0]];
          s_nxt.conv.chan = s_r.ch;
          s_nxt.conv.wr = 1'b1;
          s_nxt.rptr = s_r.rptr + (AW+1)'(1);
          s_nxt.ch = next_ch;
          if (next_ch <= s_r.ch)
          begin
            // Last enabled channel of a sample frame: one load for all of them.
            s_nxt.loaded = 1'b1;
            s_nxt.uc = s_r.uc - dws_pkg::ONE32;
            if (s_r.uc == dws_pkg::ONE32)
            begin
              s_nxt.uc = s_r.cfg.runlen;
              s_nxt.dly = s_r.cfg.gap;
              s_nxt.st = s_r.cfg.ctrl[dws_pkg::CTL_GAP_EN] ? dws_pkg::DWS_GAP
                                                            : dws_pkg::DWS_DONE;
            end
          end
        end
        // Replay a pattern that fits the queue instead of refetching it.
        if (s_r.cfg.ctrl[dws_pkg::CTL_RELOAD] && s_nxt.rptr == s_r.wptr)
        begin
          s_nxt.rptr = s_r.base;
        end
      end
      dws_pkg::DWS_GAP:
      begin
        if (s_r.dly == dws_pkg::ZERO32)
        begin
          s_nxt.st = dws_pkg::DWS_DONE;
        end
        else if (tb_tick)
        begin
          s_nxt.dly = s_r.dly - dws_pkg::ONE32;
        end
      end
      dws_pkg::DWS_DONE:
      begin
        s_nxt.ic = s_r.ic - dws_pkg::ONE32;
        s_nxt.ui = s_r.cfg.interval;
        if (!s_r.cfg.ctrl[dws_pkg::CTL_REPEAT_EN] || s_r.ic == dws_pkg::ONE32)
        begin
          s_nxt.st = dws_pkg::DWS_IDLE;
        end
        else
        begin
          // Zero gives 2^32 runs: the decrement wraps and the compare against one hits after 2^32 - 1 more decrements.
          s_nxt.st = dws_pkg::DWS_RUN;
        end
      end
      default: s_nxt.st = dws_pkg::DWS_IDLE;
    endcase
    if (wr_acc && off == dws_pkg::REG_CMD && wb_dat_i[dws_pkg::CMD_STOP])
    begin
      s_nxt.st = dws_pkg::DWS_IDLE;
    end
    if (wr_acc && off == dws_pkg::REG_CMD && wb_dat_i[dws_pkg::CMD_FIFO_CLR])
    begin
      s_nxt.wptr = '0;
      s_nxt.rptr = '0;
      s_nxt.base = '0;
    end
    // Without replay, consumed samples free their space so DMA can refill during the run.
    if (!s_r.cfg.ctrl[dws_pkg::CTL_RELOAD])
    begin
      s_nxt.base = s_nxt.rptr;
    end
    s_nxt.pin0 = s_r.conv.load && s_r.cfg.ctrl[dws_pkg::CTL_EXPORT];
    s_nxt.pin1 = s_r.conv.load && s_r.cfg.ctrl[dws_pkg::CTL_EXPORT + 1];
    s_nxt.oe0 = s_r.cfg.ctrl[dws_pkg::CTL_EXPORT];
    s_nxt.oe1 = s_r.cfg.ctrl[dws_pkg::CTL_EXPORT + 1];
    s_nxt.rdat = dws_pkg::BUS_ZERO;
    if (rd_acc)
    begin
      unique case (off)
        dws_pkg::REG_CTRL: s_nxt.rdat = s_r.cfg.ctrl;
        dws_pkg::REG_STATUS: s_nxt.rdat = {11'h000, s_r.st, 6'h00, 10'(level)};
        dws_pkg::REG_INTERVAL: s_nxt.rdat = s_r.cfg.interval;
        dws_pkg::REG_RUNLEN: s_nxt.rdat = s_r.cfg.runlen;
        dws_pkg::REG_REPEAT: s_nxt.rdat = s_r.cfg.repeats;
        dws_pkg::REG_DELAY: s_nxt.rdat = s_r.cfg.delay;
        dws_pkg::REG_GAP: s_nxt.rdat = s_r.cfg.gap;
        dws_pkg::REG_TRIGLIM: s_nxt.rdat = s_r.accepted;
        dws_pkg::REG_SWITCH: s_nxt.rdat = {28'h0000000, s_r.cfg.sw_on};
        default: s_nxt.rdat = dws_pkg::BUS_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_r <= '0;
      s_r.st <= dws_pkg::DWS_IDLE;
      s_r.cfg.ctrl <= dws_pkg::CTRL_RST;
      s_r.cfg.interval <= dws_pkg::INTERVAL_RST;
      s_r.cfg.sw_on <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // Sample storage has no reset; pointers define what is valid.
  always_ff @(posedge clk_i)
  begin
    if (fifo_push && s_r.cfg.ctrl[dws_pkg::CTL_WAVE])
    begin
      mem_r[s_r.wptr[AW-1:0]] <= wb_dat_i[dws_pkg::SAMPLE_W-1:0];
    end
  end

  assign wb_dat_o = s_r.rdat;
  assign wb_ack_o = s_r.ack;
  assign conv_o = s_r.conv;
  assign out_switch_o = s_r.cfg.sw_on;
  assign function_pin_zero_o = s_r.pin0;
  assign function_pin_one_o = s_r.pin1;
  assign function_pin_zero_oe_o = s_r.oe0;
  assign function_pin_one_oe_o = s_r.oe1;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.
  property p_load_after_wr;
    @(posedge clk_i) disable iff (rst_i) s_r.conv.wr && s_r.loaded |=> conv_o.load;
  endproperty
  a_load_after_wr: assert property (p_load_after_wr) else $error("load missing");

  property p_switch_off;
    @(posedge clk_i) $rose(rst_i) |=> out_switch_o == '0;
  endproperty
  a_switch_off: assert property (p_switch_off) else $error("switch not off");

  property p_sw_one_load;
    @(posedge clk_i) disable iff (rst_i)
      wr_acc && off == dws_pkg::REG_DATA && !s_r.cfg.ctrl[dws_pkg::CTL_WAVE]
      |=> conv_o.wr ##1 conv_o.load;
  endproperty
  a_sw_one_load: assert property (p_sw_one_load) else $error("sw update wrong");

  property p_run_ignores_trig;
    @(posedge clk_i) disable iff (rst_i)
      s_r.st == dws_pkg::DWS_RUN |=> $stable(s_r.accepted) || $past(wr_acc);
  endproperty
  a_run_ignores_trig: assert property (p_run_ignores_trig) else $error("trig counted");

  property p_limit;
    @(posedge clk_i) disable iff (rst_i)
      s_r.cfg.ctrl[dws_pkg::CTL_RETRIG] && s_r.accepted >= s_r.cfg.triglim
      && s_r.st == dws_pkg::DWS_IDLE |=> s_r.st == dws_pkg::DWS_IDLE;
  endproperty
  a_limit: assert property (p_limit) else $error("trigger over limit");

  property p_delay_holds;
    @(posedge clk_i) disable iff (rst_i)
      s_r.st == dws_pkg::DWS_DELAY && s_r.dly != '0 |=> s_r.st == dws_pkg::DWS_DELAY;
  endproperty
  a_delay_holds: assert property (p_delay_holds) else $error("delay cut short");

  property p_gap_holds;
    @(posedge clk_i) disable iff (rst_i)
      s_r.st == dws_pkg::DWS_GAP && s_r.dly != '0 |=> s_r.st == dws_pkg::DWS_GAP;
  endproperty
  a_gap_holds: assert property (p_gap_holds) else $error("gap cut short");

  property p_ui_zero;
    @(posedge clk_i) disable iff (rst_i)
      conv_o.wr && s_r.st == dws_pkg::DWS_RUN |-> $past(s_r.ui) == '0;
  endproperty
  a_ui_zero: assert property (p_ui_zero) else $error("early update");

  property p_export;
    @(posedge clk_i) disable iff (rst_i)
      conv_o.load && s_r.cfg.ctrl[dws_pkg::CTL_EXPORT] |=> function_pin_zero_o;
  endproperty
  a_export: assert property (p_export) else $error("strobe not exported");

  c_run: cover property (@(posedge clk_i) s_r.st == dws_pkg::DWS_RUN ##1 conv_o.load);
  c_gap: cover property (@(posedge clk_i) s_r.st == dws_pkg::DWS_GAP);
  c_delay: cover property (@(posedge clk_i) s_r.st == dws_pkg::DWS_DELAY);

endmodule // dws_sequencer

/* File: sim/dws_conv_model.sv */
// Behavioural model of the two dual-channel converter chips behind the sequencer.
// Assumes one-clock wr and load pulses from the sequencer, registered on clk_i.
module dws_conv_model (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Converter command bus.
  input wire dws_pkg::dws_conv_t conv_i
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] held [4];
  logic [15:0] out [4];
  logic [1:0] chan_log [$];
  int load_cnt;
  int cyc;
  int last_wr;
  int wr_gap;

  ////////////////////////////////////////////////////////////////////////////////
  // Output in millivolts from a straight binary code spanning 20 V upward from -10 V.
  function automatic int mv(input logic [15:0] c);
    return (int'(c) * 20000) / 65536 - 10000;
  endfunction

  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (rst_i)
    begin
      load_cnt <= 0;
      last_wr <= 0;
    end
    else
    begin
      if (conv_i.wr)
      begin
        held[conv_i.chan] <= conv_i.code;
        chan_log.push_back(conv_i.chan);
        wr_gap <= cyc - last_wr;
        last_wr <= cyc;
      end
      // Outputs move only on load, all at once, so a stray wr never shows early.
      if (conv_i.load)
      begin
        out <= held;
        load_cnt <= load_cnt + 1;
      end
    end
  end
endmodule // dws_conv_model

/* File: sim/tb_dws_sequencer.sv */
// Directed bench for the sequencer: Wishbone tasks and call sequences with expected values.
// Assumes a one-cycle registered ack and the converter model on the converter bus.
module tb_dws_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i, rst_i, cyc, stb, we, wb_ack_o, pin0_i, pin1_i, pin0_o, pin1_o, pin0_oe, pin1_oe;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, wb_dat_o;
  logic [3:0] sw;
  dws_pkg::dws_conv_t conv;
  int err_count, num_checks, strobes, base;

  dws_sequencer #(.DEPTH(dws_pkg::FIFO_DEPTH)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .function_pin_zero_i(pin0_i),
    .function_pin_one_i(pin1_i), .function_pin_zero_o(pin0_o), .function_pin_one_o(pin1_o),
    .function_pin_zero_oe_o(pin0_oe), .function_pin_one_oe_o(pin1_oe), .conv_o(conv),
    .out_switch_o(sw));
  dws_conv_model u_conv (.clk_i(clk_i), .rst_i(rst_i), .conv_i(conv));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    check("wb ack", 32'h1, {31'h0, wb_ack_o});
    rdat = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    check(name, exp, rdat);
  endtask

  task automatic wait_loads(input int n);
    int k;
    k = 0;
    while (u_conv.load_cnt < n && k < 4000)
    begin
      @(posedge clk_i);
      k++;
    end
    check("load count", 32'(n), 32'(u_conv.load_cnt));
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
    if (pin1_o === 1'b1)
      strobes++;

  initial
  begin
    repeat (60000) @(posedge clk_i);
    err_count++;
    print_verdict();
  end

  initial
  begin
    {cyc, stb, we, pin0_i, pin1_i, adr, wdat} = '0;
    rst_i = 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    check("switch after reset", 32'h0, {28'h0, sw});
    rd("interval reset", dws_pkg::REG_INTERVAL, dws_pkg::INTERVAL_RST);
    rd("unmapped read", 8'h3c, 32'h0);
    wb(1'b1, dws_pkg::REG_SWITCH, 32'h5);
    repeat (2) @(posedge clk_i);
    check("switch on", 32'h5, {28'h0, sw});
    // Software updates: each data write gives one load of one channel only.
    wb(1'b1, dws_pkg::REG_CTRL, 32'hf);
    base = u_conv.load_cnt;
    wb(1'b1, dws_pkg::REG_DATA, 32'h0002_c000);
    repeat (4) @(posedge clk_i);
    check("sw loads", 32'(base + 1), 32'(u_conv.load_cnt));
    check("ch2 mv", 32'(5000), 32'(u_conv.mv(u_conv.out[2])));
    wb(1'b1, dws_pkg::REG_DATA, 32'h0000_0000);
    repeat (4) @(posedge clk_i);
    check("sw loads", 32'(base + 2), 32'(u_conv.load_cnt));
    check("ch0 mv", 32'(-10000), 32'(u_conv.mv(u_conv.out[0])));
    check("ch2 held", 32'hc000, {16'h0, u_conv.out[2]});
    // Waveform: channels 0, 1, 3, one frame a run, two runs replayed from the queue.
    wb(1'b1, dws_pkg::REG_CMD, 32'h4);
    wb(1'b1, dws_pkg::REG_CTRL, 32'h0000_28db);
    wb(1'b1, dws_pkg::REG_INTERVAL, 32'h50);
    wb(1'b1, dws_pkg::REG_RUNLEN, 32'h1);
    wb(1'b1, dws_pkg::REG_REPEAT, 32'h2);
    wb(1'b1, dws_pkg::REG_TRIGLIM, 32'h1);
    wb(1'b1, dws_pkg::REG_DATA, 32'hffff);
    wb(1'b1, dws_pkg::REG_DATA, 32'h0001);
    wb(1'b1, dws_pkg::REG_DATA, 32'h0102);
    wb(1'b0, dws_pkg::REG_STATUS, 32'h0);
    check("queue level", 32'h3, {22'h0, rdat[9:0]});
    check("export enable", 32'h1, {31'h0, pin1_oe});
    base = u_conv.load_cnt;
    strobes = 0;
    u_conv.chan_log.delete();
    @(posedge clk_i);
    pin0_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    pin0_i <= 1'b0;
    wait_loads(base + 2);
    repeat (1500) @(posedge clk_i);
    check("run loads", 32'(base + 2), 32'(u_conv.load_cnt));
    check("strobes", 32'h2, 32'(strobes));
    check("writes", 32'h6, 32'(u_conv.chan_log.size()));
    for (int i = 0; i < 6; i++)
      check("chan order", (i % 3 == 2) ? 32'h3 : 32'(i % 3), 32'(u_conv.chan_log[i]));
    check("write spacing", 32'd200, 32'(u_conv.wr_gap));
    check("ch0 out", 32'hffff, {16'h0, u_conv.out[0]});
    check("ch1 out", 32'h0001, {16'h0, u_conv.out[1]});
    check("ch3 out", 32'h0102, {16'h0, u_conv.out[3]});
    rd("tally", dws_pkg::REG_TRIGLIM, 32'h1);
    wb(1'b1, dws_pkg::REG_CMD, 32'h1);
    repeat (2000) @(posedge clk_i);
    check("over limit", 32'(base + 2), 32'(u_conv.load_cnt));
    wb(1'b1, dws_pkg::REG_CMD, 32'h2);
    rd("tally cleared", dws_pkg::REG_TRIGLIM, 32'h0);
    wb(1'b1, dws_pkg::REG_CMD, 32'h1);
    wait_loads(base + 4);
    // Delay on the system clock, then two runs separated by a gap.
    wb(1'b1, dws_pkg::REG_DELAY, 32'h40);
    wb(1'b1, dws_pkg::REG_GAP, 32'h20);
    wb(1'b1, dws_pkg::REG_CTRL, 32'h0000_3abb);
    wb(1'b1, dws_pkg::REG_CMD, 32'h1);
    rd("status in delay", dws_pkg::REG_STATUS, 32'h0002_0003);
    wait_loads(base + 6);
    print_verdict();
  end
endmodule // tb_dws_sequencer
